// ==== include/instr_exec_pkg.sv ====
// Package for the instruction execution unit: opcodes, carriers, flag
// layout, register map and bus answer codes.
// Assumes a SystemVerilog compiler; used by verilog/instr_exec_unit.sv.
package instr_exec_pkg;

  // ----------------------------------------------------------------------
  // Widths and constants
  // ----------------------------------------------------------------------
  localparam int          DATA_W      = 8;
  localparam int          DM_AW       = 8;
  localparam int          BIT_SEL_W   = 3;
  localparam logic [7:0]  BYTE_ONE    = 8'h01;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  BYTE_ALL_ONES = 8'hFF;
  localparam int          NIB_W       = 4;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OFS_WORK       = 8'h00;
  localparam logic [7:0]  OFS_FLAGS      = 8'h04;
  localparam logic [7:0]  OFS_PTR_LOW    = 8'h08;
  localparam logic [7:0]  OFS_PTR_HIGH   = 8'h0C;
  localparam logic [7:0]  OFS_HIGH_LATCH = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;
  localparam int          REG_AW         = 8;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // Flag bit positions inside the flag register
  localparam int FLAG_BORROW_NOT = 0;
  localparam int FLAG_NULL       = 1;
  localparam int FLAG_HALF       = 2;
  localparam int FLAG_EXCESS     = 3;
  localparam int FLAG_N          = 4;

  // ----------------------------------------------------------------------
  // Opcodes and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP,
    OP_SUB_BORROW_TO_MEM,
    OP_SUB_BORROW_TO_WORK,
    OP_MINUS_MEM,
    OP_MINUS_TO_MEM,
    OP_MINUS_IMM,
    OP_DEC_SKIP_ZERO,
    OP_DEC_TO_WORK_SKIP,
    OP_INC_SKIP_ZERO,
    OP_INC_TO_WORK_SKIP,
    OP_BYTE_SET,
    OP_BIT_SET,
    OP_SKIP_BIT_NONZERO,
    OP_SKIP_BIT_ZERO,
    OP_NIBBLE_SWAP,
    OP_NIBBLE_EXCH_TO_WORK,
    OP_SKIP_IF_ZERO,
    OP_COPY_SKIP_ZERO,
    OP_TABLE_READ_PAGED,
    OP_TABLE_READ_CURRENT,
    OP_TABLE_READ_LAST,
    OP_XOR_MEM,
    OP_EXCLUSIVE_OR_TO_MEM,
    OP_XOR_IMM
  } op_t;

  typedef struct packed {
    op_t                  op;
    logic [DM_AW-1:0]     addr;
    logic [BIT_SEL_W-1:0] bit_sel;
    logic [DATA_W-1:0]    imm;
  } instr_t;

  typedef struct packed {
    logic signed_excess_flag;
    logic half_borrow_flag;
    logic null_result_flag;
    logic borrow_not_flag;
  } flags_t;

endpackage : instr_exec_pkg

// ==== verilog/instr_exec_unit.sv ====
// Execution unit for a subset of an 8-bit controller instruction set,
// with its architectural registers reachable over AXI4-Lite.
// Assumes data memory and program memory answer a read one cycle after
// the read strobe, and that decode offers one instruction at a time.
`timescale 1ns/1ps

module instr_exec_unit
  import instr_exec_pkg::*;
#(
  parameter int PAGE_W = 4,
  parameter int PW     = 16
)(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Instruction from decode
  input  wire logic                  instr_valid,
  output      logic                  instr_ready,
  input  wire instr_t                instr,
  input  wire logic [PAGE_W-1:0]     current_page,
  output      logic                  done,
  output      logic                  skip,
  output      logic                  dummy_cycle,
  // Data memory
  output      logic [DM_AW-1:0]      dm_addr,
  output      logic                  dm_rd,
  output      logic                  dm_we,
  output      logic [DATA_W-1:0]     dm_wdata,
  input  wire logic [DATA_W-1:0]     dm_rdata,
  // Program memory
  output      logic [PAGE_W+7:0]     pm_addr,
  output      logic                  pm_rd,
  input  wire logic [PW-1:0]         pm_rdata,
  // Architectural state
  output      logic [DATA_W-1:0]     work_register,
  output      flags_t                flags,
  output      logic [PW-DATA_W-1:0]  table_high_latch,
  // AXI4-Lite slave
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      logic [31:0]           s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_MEM, ST_PRD, ST_PDAT, ST_DUMMY
  } state_t;

  typedef struct packed {
    logic [DATA_W-1:0] res;
    flags_t            fl;
  } sub_t;

  localparam logic [PAGE_W-1:0] LAST_PAGE = {PAGE_W{1'b1}};

  state_t                state_ff;
  state_t                nxt_state;
  instr_t                instr_ff;
  logic [DATA_W-1:0]     work_ff;
  logic [DATA_W-1:0]     nxt_work;
  logic                  work_we;
  flags_t                flags_ff;
  flags_t                nxt_flags;
  logic                  flags_we;
  logic [PW-DATA_W-1:0]  high_latch_ff;
  logic [DATA_W-1:0]     ptr_low_ff;
  logic [PAGE_W-1:0]     ptr_high_ff;
  logic [DM_AW-1:0]      dm_addr_ff;
  logic                  dm_rd_ff;
  logic                  dm_we_ff;
  logic [DATA_W-1:0]     dm_wdata_ff;
  logic [DATA_W-1:0]     nxt_mem;
  logic                  mem_we;
  logic [PAGE_W+7:0]     pm_addr_ff;
  logic                  pm_rd_ff;
  logic                  done_ff;
  logic                  skip_ff;
  logic                  nxt_skip;
  logic                  dummy_ff;
  logic [DATA_W-1:0]     opnd;
  logic [DATA_W-1:0]     mask;
  logic [DATA_W-1:0]     dec_val;
  logic [DATA_W-1:0]     inc_val;
  logic [DATA_W-1:0]     swapped;
  logic [DATA_W-1:0]     xor_val;
  sub_t                  sub_res;
  logic                  accept;
  logic                  is_table;
  logic                  use_borrow;
  // Bus side
  logic                  aw_got_ff;
  logic                  w_got_ff;
  logic [REG_AW-1:0]     aw_addr_ff;
  logic [DATA_W-1:0]     w_data_ff;
  logic                  w_strb0_ff;
  logic                  bvalid_ff;
  logic [1:0]            bresp_ff;
  logic                  rvalid_ff;
  logic [31:0]           rdata_ff;
  logic [1:0]            rresp_ff;
  logic                  bus_wr;
  logic                  wr_hit;
  logic [REG_AW-1:0]     rd_addr;

  // ----------------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------------
  function automatic sub_t subtract(input logic [DATA_W-1:0] a,
                                    input logic [DATA_W-1:0] b,
                                    input logic              bin);
    logic [DATA_W:0]    full;
    logic [NIB_W:0]     low;
    sub_t               s;
    full = {1'b0, a} - {1'b0, b} - {{DATA_W{1'b0}}, bin};
    low  = {1'b0, a[NIB_W-1:0]} - {1'b0, b[NIB_W-1:0]}
           - {{NIB_W{1'b0}}, bin};
    s.res                   = full[DATA_W-1:0];
    s.fl.borrow_not_flag    = ~full[DATA_W];
    s.fl.null_result_flag   = (full[DATA_W-1:0] == BYTE_ZERO);
    s.fl.half_borrow_flag   = low[NIB_W];
    s.fl.signed_excess_flag = (a[DATA_W-1] ^ b[DATA_W-1])
                              & (a[DATA_W-1] ^ full[DATA_W-1]);
    return s;
  endfunction : subtract

  assign accept   = instr_valid & (state_ff == ST_IDLE);
  assign is_table = (instr.op == OP_TABLE_READ_PAGED)
                    | (instr.op == OP_TABLE_READ_CURRENT)
                    | (instr.op == OP_TABLE_READ_LAST);
  assign opnd     = ((instr_ff.op == OP_MINUS_IMM)
                     | (instr_ff.op == OP_XOR_IMM))
                    ? instr_ff.imm : dm_rdata;
  assign mask     = BYTE_ONE << instr_ff.bit_sel;
  assign dec_val  = dm_rdata - BYTE_ONE;
  assign inc_val  = dm_rdata + BYTE_ONE;
  assign swapped  = {dm_rdata[NIB_W-1:0], dm_rdata[DATA_W-1:NIB_W]};
  assign xor_val  = work_ff ^ opnd;
  assign use_borrow = (instr_ff.op == OP_SUB_BORROW_TO_MEM)
                      | (instr_ff.op == OP_SUB_BORROW_TO_WORK);
  // Borrow-in is the inverse of the stored borrow_not flag for the two borrow ops, zero for the others
  assign sub_res  = subtract(work_ff, opnd,
                             use_borrow & ~flags_ff.borrow_not_flag);

  // ----------------------------------------------------------------------
  // Per-instruction result selection, valid in ST_MEM
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_work  = work_ff;
    nxt_flags = flags_ff;
    nxt_mem   = dm_rdata;
    work_we   = 1'b0;
    flags_we  = 1'b0;
    mem_we    = 1'b0;
    nxt_skip  = 1'b0;
    if (state_ff == ST_MEM)
    begin
      case (instr_ff.op)
        OP_SUB_BORROW_TO_MEM, OP_MINUS_TO_MEM:
        begin
          nxt_mem   = sub_res.res;
          mem_we    = 1'b1;
          nxt_flags = sub_res.fl;
          flags_we  = 1'b1;
        end
        OP_SUB_BORROW_TO_WORK, OP_MINUS_MEM, OP_MINUS_IMM:
        begin
          nxt_work  = sub_res.res;
          work_we   = 1'b1;
          nxt_flags = sub_res.fl;
          flags_we  = 1'b1;
        end
        OP_DEC_SKIP_ZERO:
        begin
          nxt_mem  = dec_val;
          mem_we   = 1'b1;
          nxt_skip = (dec_val == BYTE_ZERO);
        end
        OP_DEC_TO_WORK_SKIP:
        begin
          nxt_work = dec_val;
          work_we  = 1'b1;
          nxt_skip = (dec_val == BYTE_ZERO);
        end
        OP_INC_SKIP_ZERO:
        begin
          nxt_mem  = inc_val;
          mem_we   = 1'b1;
          nxt_skip = (inc_val == BYTE_ZERO);
        end
        OP_INC_TO_WORK_SKIP:
        begin
          nxt_work = inc_val;
          work_we  = 1'b1;
          nxt_skip = (inc_val == BYTE_ZERO);
        end
        OP_BYTE_SET:
        begin
          nxt_mem = BYTE_ALL_ONES;
          mem_we  = 1'b1;
        end
        OP_BIT_SET:
        begin
          nxt_mem = dm_rdata | mask;
          mem_we  = 1'b1;
        end
        OP_SKIP_BIT_NONZERO: nxt_skip = |(dm_rdata & mask);
        OP_SKIP_BIT_ZERO:    nxt_skip = ~|(dm_rdata & mask);
        OP_NIBBLE_SWAP:
        begin
          nxt_mem = swapped;
          mem_we  = 1'b1;
        end
        OP_NIBBLE_EXCH_TO_WORK:
        begin
          nxt_work = swapped;
          work_we  = 1'b1;
        end
        OP_SKIP_IF_ZERO: nxt_skip = (dm_rdata == BYTE_ZERO);
        OP_COPY_SKIP_ZERO:
        begin
          nxt_work = dm_rdata;
          work_we  = 1'b1;
          nxt_skip = (dm_rdata == BYTE_ZERO);
        end
        OP_XOR_MEM, OP_XOR_IMM:
        begin
          nxt_work = xor_val;
          work_we  = 1'b1;
          nxt_flags.null_result_flag = (xor_val == BYTE_ZERO);
          flags_we = 1'b1;
        end
        OP_EXCLUSIVE_OR_TO_MEM:
        begin
          nxt_mem  = xor_val;
          mem_we   = 1'b1;
          nxt_flags.null_result_flag = (xor_val == BYTE_ZERO);
          flags_we = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    case (state_ff)
      ST_IDLE:  nxt_state = accept ? (is_table ? ST_PRD : ST_RD) : ST_IDLE;
      ST_RD:    nxt_state = ST_MEM;
      ST_MEM:   nxt_state = nxt_skip ? ST_DUMMY : ST_IDLE;
      ST_PRD:   nxt_state = ST_PDAT;
      ST_PDAT:  nxt_state = ST_IDLE;
      ST_DUMMY: nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      instr_ff <= '0;
    else if (accept)
      instr_ff <= instr;
  end

  // Completion, skip and dummy fetch indications
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_ff  <= 1'b0;
      skip_ff  <= 1'b0;
      dummy_ff <= 1'b0;
    end
    else
    begin
      done_ff  <= (state_ff == ST_MEM) | (state_ff == ST_PDAT);
      skip_ff  <= (state_ff == ST_MEM) & nxt_skip;
      dummy_ff <= (state_ff == ST_MEM) & nxt_skip;
    end
  end

  // ----------------------------------------------------------------------
  // Data and program memory ports
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dm_addr_ff  <= '0;
      dm_rd_ff    <= 1'b0;
      dm_we_ff    <= 1'b0;
      dm_wdata_ff <= RST_BYTE;
    end
    else
    begin
      dm_rd_ff <= accept & ~is_table;
      dm_we_ff <= mem_we | (state_ff == ST_PDAT);
      if (accept)
        dm_addr_ff <= instr.addr;
      if (state_ff == ST_PDAT)
        dm_wdata_ff <= pm_rdata[DATA_W-1:0];
      else if (mem_we)
        dm_wdata_ff <= nxt_mem;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pm_addr_ff <= '0;
      pm_rd_ff   <= 1'b0;
    end
    else
    begin
      pm_rd_ff <= accept & is_table;
      if (accept)
      begin
        case (instr.op)
          OP_TABLE_READ_PAGED:
            pm_addr_ff <= {ptr_high_ff, ptr_low_ff};
          OP_TABLE_READ_CURRENT:
            pm_addr_ff <= {current_page, ptr_low_ff};
          OP_TABLE_READ_LAST:
            pm_addr_ff <= {LAST_PAGE, ptr_low_ff};
          default:               pm_addr_ff <= pm_addr_ff;
        endcase
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      high_latch_ff <= '0;
    else if (state_ff == ST_PDAT)
      high_latch_ff <= pm_rdata[PW-1:DATA_W];
  end

  // ----------------------------------------------------------------------
  // Work register, flags and table pointers
  // ----------------------------------------------------------------------
  // Execution wins over a bus write landing in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      work_ff <= RST_BYTE;
    else if (work_we)
      work_ff <= nxt_work;
    else if (wr_hit && aw_addr_ff == OFS_WORK)
      work_ff <= w_data_ff;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_ff <= '0;
    else if (flags_we)
      flags_ff <= nxt_flags;
    else if (wr_hit && aw_addr_ff == OFS_FLAGS)
      flags_ff <= w_data_ff[FLAG_N-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptr_low_ff  <= RST_BYTE;
      ptr_high_ff <= '0;
    end
    else
    begin
      if (wr_hit && aw_addr_ff == OFS_PTR_LOW)
        ptr_low_ff <= w_data_ff;
      if (wr_hit && aw_addr_ff == OFS_PTR_HIGH)
        ptr_high_ff <= w_data_ff[PAGE_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  assign bus_wr = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wr_hit = bus_wr & w_strb0_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= RST_BYTE;
      w_strb0_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr[REG_AW-1:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff   <= 1'b1;
        w_data_ff  <= s_axi_wdata[DATA_W-1:0];
        w_strb0_ff <= s_axi_wstrb[0];
      end
      if (bus_wr)
      begin
        bvalid_ff <= 1'b1;
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bresp_ff  <= (aw_addr_ff == OFS_WORK || aw_addr_ff == OFS_FLAGS
                      || aw_addr_ff == OFS_PTR_LOW
                      || aw_addr_ff == OFS_PTR_HIGH)
                     ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  assign rd_addr = s_axi_araddr[REG_AW-1:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      case (rd_addr)
        OFS_WORK:       rdata_ff <= {24'h000000, work_ff};
        OFS_FLAGS:      rdata_ff <= {28'h0000000, flags_ff};
        OFS_PTR_LOW:    rdata_ff <= {24'h000000, ptr_low_ff};
        OFS_PTR_HIGH:   rdata_ff <= 32'(ptr_high_ff);
        OFS_HIGH_LATCH: rdata_ff <= 32'(high_latch_ff);
        OFS_STATUS:     rdata_ff <= {31'h0, state_ff != ST_IDLE};
        default:
        begin
          rdata_ff <= '0;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign instr_ready      = (state_ff == ST_IDLE);
  assign done             = done_ff;
  assign skip             = skip_ff;
  assign dummy_cycle      = dummy_ff;
  assign dm_addr          = dm_addr_ff;
  assign dm_rd            = dm_rd_ff;
  assign dm_we            = dm_we_ff;
  assign dm_wdata         = dm_wdata_ff;
  assign pm_addr          = pm_addr_ff;
  assign pm_rd            = pm_rd_ff;
  assign work_register    = work_ff;
  assign flags            = flags_ff;
  assign table_high_latch = high_latch_ff;
  assign s_axi_awready    = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready     = ~w_got_ff & ~bvalid_ff;
  assign s_axi_bvalid     = bvalid_ff;
  assign s_axi_bresp      = bresp_ff;
  assign s_axi_arready    = ~rvalid_ff;
  assign s_axi_rvalid     = rvalid_ff;
  assign s_axi_rdata      = rdata_ff;
  assign s_axi_rresp      = rresp_ff;

endmodule : instr_exec_unit

// ==== bench/exec_mem_model.sv ====
// Behavioural data and program memory beside the execution unit.
// Assumes each read is strobed one cycle before its data is used.
`timescale 1ns/1ps
module exec_mem_model
  import instr_exec_pkg::*;
(
  input  wire logic [0:0]        aclk,
  input  wire logic [DM_AW-1:0]  dm_addr,
  input  wire logic              dm_rd,
  input  wire logic              dm_we,
  input  wire logic [DATA_W-1:0] dm_wdata,
  output      logic [DATA_W-1:0] dm_rdata = 8'h00,
  input  wire logic [11:0]       pm_addr,
  input  wire logic              pm_rd,
  output      logic [15:0]       pm_rdata = 16'h0000
);
  logic [7:0] mem [256];
  // Data flips outside a read so that a late sample cannot pass
  always @(posedge aclk)
  begin
    if (dm_we) mem[dm_addr] <= dm_wdata;
    dm_rdata <= dm_rd ? mem[dm_addr] : ~dm_rdata;
    pm_rdata <= pm_rd ? {4'hA, pm_addr} : ~pm_rdata;
  end
endmodule : exec_mem_model

// ==== bench/instr_exec_monitor.sv ====
// Port assertions for the execution unit.
// Assumes binding into instr_exec_unit.
`timescale 1ns/1ps
module instr_exec_monitor
  import instr_exec_pkg::*;
#(parameter int PAGE_W = 4)(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              instr_valid,
  input wire logic              instr_ready,
  input wire instr_t            instr,
  input wire logic [PAGE_W-1:0] current_page,
  input wire logic              done,
  input wire logic              skip,
  input wire logic              dummy_cycle,
  input wire logic              dm_we,
  input wire logic [DATA_W-1:0] dm_wdata,
  input wire logic [PAGE_W+7:0] pm_addr,
  input wire flags_t            flags
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic took;
  assign took = instr_valid && instr_ready;
  AST_SKIP_TWO_CYCLES:
    assert property (skip |-> done && dummy_cycle && !instr_ready ##1
      instr_ready) else $error("skip timing");
  AST_READY_NO_SKIP:
    assert property (done && !skip |-> instr_ready) else $error("stall");
  AST_DONE_THIRD:
    assert property (took |=> !done ##1 !done ##1 done) else $error("done");
  AST_SET_ONES:
    assert property (took && instr.op == OP_BYTE_SET |-> ##3 dm_we &&
      dm_wdata == BYTE_ALL_ONES) else $error("byte set");
  AST_WORK_ONLY:
    assert property (took && instr.op inside {OP_DEC_TO_WORK_SKIP,
      OP_INC_TO_WORK_SKIP, OP_NIBBLE_EXCH_TO_WORK, OP_COPY_SKIP_ZERO}
      |=> !dm_we [*3]) else $error("memory written");
  AST_FLAGS_KEPT:
    assert property (took && instr.op inside {[OP_DEC_SKIP_ZERO:
      OP_TABLE_READ_LAST]} |=> $stable(flags) [*3]) else $error("flags");
  AST_XOR_NULL_ONLY:
    assert property (took && instr.op inside {[OP_XOR_MEM:OP_XOR_IMM]} |->
      ##3 (flags & 4'hD) == ($past(flags, 3) & 4'hD)) else $error("xor");
  AST_LAST_PAGE:
    assert property (took && instr.op == OP_TABLE_READ_LAST |=>
      pm_addr[PAGE_W+7:8] == {PAGE_W{1'b1}}) else $error("last page");
  AST_CUR_PAGE:
    assert property (took && instr.op == OP_TABLE_READ_CURRENT |=>
      pm_addr[PAGE_W+7:8] == $past(current_page)) else $error("page");
endmodule : instr_exec_monitor

bind instr_exec_unit instr_exec_monitor #(.PAGE_W(PAGE_W)) mon (.aclk,
  .aresetn, .instr_valid, .instr_ready, .instr, .current_page, .done,
  .skip, .dummy_cycle, .dm_we, .dm_wdata, .pm_addr, .flags);

// ==== bench/tb.sv ====
// Self-checking bench: random and corner operands for every opcode except the table reads, which get random pointers only.
// Assumes the memory model answers one cycle after each read strobe.
`timescale 1ns/1ps
module tb
  import instr_exec_pkg::*;
;
  logic aclk = 0, aresetn = 0, instr_valid = 0, instr_ready, done, skip;
  logic dummy_cycle, dm_rd, dm_we, pm_rd, s_axi_awready, s_axi_wready, sk;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_arready, s_axi_rvalid;
  logic s_axi_bvalid;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF, current_page = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]  dm_addr, dm_wdata, dm_rdata, work_register, table_high_latch;
  logic [7:0]  lf = 8'h56, w, m, fi, b, im, a, pl, ph;
  logic [11:0] pm_addr, pa;
  logic [15:0] pm_rdata;
  logic [20:0] e;
  instr_t      instr = '0;
  flags_t      flags;
  op_t         op;
  int          err_total = 0, n_checks = 0, cyc = 0;
  instr_exec_unit DUT (.*);
  exec_mem_model mem_i (.*);
  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      err_total++;
      give_verdict();
    end
  end
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction : rnd
  function automatic logic [20:0] expect_of(op_t o, logic [7:0] w, m, im,
                                            logic [2:0] b, logic [3:0] f);
    logic [7:0] y;
    logic [8:0] r;
    logic       c;
    logic       s;
    c = (o inside {OP_SUB_BORROW_TO_MEM, OP_SUB_BORROW_TO_WORK}) & ~f[0];
    y = (o inside {OP_MINUS_IMM, OP_XOR_IMM}) ? im : m;
    r = {1'b0, w} - {1'b0, y} - {8'h00, c};
    if (o inside {[OP_SUB_BORROW_TO_MEM:OP_MINUS_IMM]})
      f = {(w[7] != y[7]) && (r[7] != w[7]), {1'b0, w[3:0]} <
           {1'b0, y[3:0]} + {4'h0, c}, r[7:0] == 8'h00, ~r[8]};
    if (o inside {[OP_XOR_MEM:OP_XOR_IMM]}) f[1] = (w ^ y) == 8'h00;
    case (o)
      OP_SUB_BORROW_TO_MEM, OP_MINUS_TO_MEM: m = r[7:0];
      OP_SUB_BORROW_TO_WORK, OP_MINUS_MEM, OP_MINUS_IMM: w = r[7:0];
      OP_DEC_SKIP_ZERO: m = m - 8'h01;
      OP_DEC_TO_WORK_SKIP: w = m - 8'h01;
      OP_INC_SKIP_ZERO: m = m + 8'h01;
      OP_INC_TO_WORK_SKIP: w = m + 8'h01;
      OP_BYTE_SET: m = 8'hFF;
      OP_BIT_SET: m[b] = 1'b1;
      OP_NIBBLE_SWAP: m = {m[3:0], m[7:4]};
      OP_NIBBLE_EXCH_TO_WORK: w = {m[3:0], m[7:4]};
      OP_COPY_SKIP_ZERO: w = m;
      OP_XOR_MEM, OP_XOR_IMM: w = w ^ y;
      OP_EXCLUSIVE_OR_TO_MEM: m = w ^ m;
      default: ;
    endcase
    s = (o inside {OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO, OP_SKIP_IF_ZERO}
         && m == 8'h00) || (o == OP_SKIP_BIT_NONZERO && m[b]) ||
        (o inside {OP_DEC_TO_WORK_SKIP, OP_INC_TO_WORK_SKIP,
         OP_COPY_SKIP_ZERO} && w == 8'h00) || (o == OP_SKIP_BIT_ZERO && !m[b]);
    return {s, w, m, f};
  endfunction : expect_of
  task automatic chk(logic [15:0] g, logic [15:0] x, string t);
    n_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, t, g, x);
    end
  endtask : chk
  task automatic axw(logic [7:0] ad, logic [31:0] d, logic [3:0] st);
    @(posedge aclk);
    s_axi_awaddr <= 32'(ad);
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(logic [7:0] ad);
    @(posedge aclk);
    s_axi_araddr <= 32'(ad);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic run(instr_t i);
    @(posedge aclk);
    instr <= i;
    instr_valid <= 1'b1;
    do @(posedge aclk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    do @(posedge aclk); while (done !== 1'b1);
    sk = skip;
    #1;
  endtask : run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      for (int o = 0; o < 24; o++)
      begin
        if (o inside {[18:20]}) continue;
        op = op_t'(o);
        {w, m, fi, b, im, a} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        // Second pass: zero-crossing and signed-overflow operands
        if (p == 1) {w, fi, m} = {8'h80, 8'h00, op inside {OP_DEC_SKIP_ZERO,
          OP_DEC_TO_WORK_SKIP} ? 8'h01 : op inside {OP_INC_SKIP_ZERO,
          OP_INC_TO_WORK_SKIP} ? 8'hFF : 8'h00};
        axw(OFS_WORK, 32'(w), 4'hF);
        axw(OFS_FLAGS, 32'(fi[3:0]), 4'hF);
        mem_i.mem[a] = m;
        run({op, a, b[2:0], im});
        e = expect_of(op, w, m, im, b[2:0], fi[3:0]);
        chk(16'(work_register), 16'(e[19:12]), "work");
        chk(16'(mem_i.mem[a]), 16'(e[11:4]), "mem");
        chk(16'(flags), 16'(e[3:0]), "flags");
        chk(16'(sk), 16'(e[20]), "skip");
      end
      $display("opcode pass %0d done", p);
    end
    for (int t = 0; t < 3; t++)
    begin
      {pl, ph, a} = {rnd(), rnd(), rnd()};
      axw(OFS_PTR_LOW, 32'(pl), 4'hF);
      axw(OFS_PTR_HIGH, 32'(ph[3:0]), 4'hF);
      current_page <= ph[7:4];
      run({op_t'(18 + t), a, 3'h0, 8'h00});
      pa = (t == 0) ? {ph[3:0], pl} : (t == 1) ? {ph[7:4], pl} : {4'hF, pl};
      chk(16'(mem_i.mem[a]), 16'(pa[7:0]), "low");
      axr(OFS_HIGH_LATCH);
      chk(rd[15:0], 16'({4'hA, pa[11:8]}), "high");
      chk(16'(table_high_latch), 16'({4'hA, pa[11:8]}), "latch");
    end
    axr(8'h40);
    chk(16'(rsp), 16'(RESP_SLVERR), "unmapped");
    axw(OFS_STATUS, 32'h00000001, 4'hF);
    chk(16'(rsp), 16'(RESP_SLVERR), "read-only");
    axr(OFS_STATUS);
    chk(rd[15:0], 16'h0000, "idle status");
    $display("table and bus tests done");
    give_verdict();
  end
endmodule : tb
